// [design/input_priority_pkg.sv]
package input_priority_pkg;

    // Geometry of the priority fields.
    localparam int NUM_INPUTS = 4;
    localparam int PRIO_W = 4;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;

    // Register offsets on the processor port.
    localparam logic [7:0] INPUT9_10_PRIORITY_OFFSET = 8'h1C;
    localparam logic [7:0] INPUT11_12_PRIORITY_OFFSET = 8'h1D;
    localparam logic [7:0] SOURCE_SELECT_OFFSET = 8'h4B;

    // Field positions.
    localparam int PATH_BANK_SELECT_BIT = 4;
    localparam int LOW_FIELD_LSB = 0;
    localparam int HIGH_FIELD_LSB = 4;

    // Values after reset.
    localparam logic [7:0] INPUT9_10_MAIN_RESET = 8'hBA;
    localparam logic [7:0] INPUT9_10_AUX_RESET = 8'hBA;
    localparam logic [7:0] INPUT11_12_MAIN_RESET = 8'hDC;
    localparam logic [7:0] INPUT11_12_AUX_RESET = 8'h00;
    localparam logic PATH_BANK_SELECT_RESET = 1'b0;

    // Field value that excludes an input from automatic selection.
    localparam logic [3:0] PRIO_DISABLED = 4'h0;

    // Read answer for unmapped addresses and idle cycles.
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

endpackage

// [design/prio_path_copy.sv]
`timescale 1ns/1ps

module prio_path_copy #(
    parameter logic [7:0] RESET_9_10 = 8'hBA,
    parameter logic [7:0] RESET_11_12 = 8'hDC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Write side.
    input wire logic wr_9_10,
    input wire logic wr_11_12,
    input wire logic [7:0] wr_data,
    // Stored bytes.
    output logic [7:0] pair_9_10_reg,
    output logic [7:0] pair_11_12_reg
);

    // The byte for inputs nine and ten.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pair_9_10_reg <= RESET_9_10;
        end
        else if (wr_9_10)
        begin
            pair_9_10_reg <= wr_data;
        end
    end

    // The byte for inputs eleven and twelve.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pair_11_12_reg <= RESET_11_12;
        end
        else if (wr_11_12)
        begin
            pair_11_12_reg <= wr_data;
        end
    end

endmodule // prio_path_copy

// [design/prio_pick.sv]
`timescale 1ns/1ps

module prio_pick #(
    parameter int N = 4,
    parameter int W = 4,
    parameter int IDX_W = 2
) (
    // Priority fields, entry zero first, and availability.
    input wire logic [N-1:0][W-1:0] prio,
    input wire logic [N-1:0] available,
    // Selection result.
    output logic [N-1:0] eligible,
    output logic best_valid,
    output logic [IDX_W-1:0] best_idx,
    output logic [W-1:0] best_prio
);

    // A zero field takes the input out of automatic selection.
    for (genvar g = 0; g < N; g++)
    begin : g_elig
        assign eligible[g] = (prio[g] != {W{1'b0}}) && available[g];
    end

    // The smallest nonzero value wins; a tie keeps the lower entry.
    always_comb
    begin
        best_valid = 1'b0;
        best_idx = '0;
        best_prio = '0;
        for (int i = 0; i < N; i++)
        begin
            if (eligible[i] && (!best_valid || prio[i] < best_prio))
            begin
                best_valid = 1'b1;
                best_idx = IDX_W'(i);
                best_prio = prio[i];
            end
        end
    end

endmodule // prio_pick

// [design/input_priority_config_regs.sv]
// Our own choice: the strobed register port.
`timescale 1ns/1ps

// Function
// - Each input has a 4-bit priority; smaller nonzero value means higher.
// - Value zero excludes the input; one to fifteen make it eligible while its input_available bit is set.
// - Separate main and aux path copies; bank select bit four picks one.
// - Byte one holds inputs ten and nine, reset 8'hBA in both copies.
// - Byte two holds inputs twelve and eleven, one copy per path.
module input_priority_config_regs (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Processor port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    // Inputs currently passing their quality checks, input nine in bit 0.
    input wire logic [3:0] input_available,
    // Current path bank select.
    output logic path_bank_select,
    // Main clock path priorities and selection.
    output logic [3:0][3:0] main_prio,
    output logic [3:0] main_eligible,
    output logic main_best_valid,
    output logic [1:0] main_best_idx,
    output logic [3:0] main_best_prio,
    // Aux clock path priorities and selection.
    output logic [3:0][3:0] aux_prio,
    output logic [3:0] aux_eligible,
    output logic aux_best_valid,
    output logic [1:0] aux_best_idx,
    output logic [3:0] aux_best_prio
);

    logic bank_sel_reg;
    logic [7:0] rd_data_reg;
    logic hit_9_10;
    logic hit_11_12;
    logic hit_select;
    logic main_wr_9_10;
    logic main_wr_11_12;
    logic aux_wr_9_10;
    logic aux_wr_11_12;
    logic [7:0] main_9_10;
    logic [7:0] main_11_12;
    logic [7:0] aux_9_10;
    logic [7:0] aux_11_12;
    logic [7:0] rd_next;
    logic [3:0][3:0] main_prio_next;
    logic [3:0][3:0] aux_prio_next;
    logic [3:0] main_elig_next;
    logic [3:0] aux_elig_next;
    logic main_valid_next;
    logic aux_valid_next;
    logic [1:0] main_idx_next;
    logic [1:0] aux_idx_next;
    logic [3:0] main_bprio_next;
    logic [3:0] aux_bprio_next;
    logic [3:0][3:0] main_prio_reg;
    logic [3:0][3:0] aux_prio_reg;
    logic [3:0] main_elig_reg;
    logic [3:0] aux_elig_reg;
    logic main_valid_reg;
    logic aux_valid_reg;
    logic [1:0] main_idx_reg;
    logic [1:0] aux_idx_reg;
    logic [3:0] main_bprio_reg;
    logic [3:0] aux_bprio_reg;

    // Address decode.
    assign hit_9_10 = (addr == input_priority_pkg::INPUT9_10_PRIORITY_OFFSET);
    assign hit_11_12 =
        (addr == input_priority_pkg::INPUT11_12_PRIORITY_OFFSET);
    assign hit_select = (addr == input_priority_pkg::SOURCE_SELECT_OFFSET);

    assign main_wr_9_10 = wr_strobe && hit_9_10 && !bank_sel_reg;
    assign main_wr_11_12 = wr_strobe && hit_11_12 && !bank_sel_reg;
    assign aux_wr_9_10 = wr_strobe && hit_9_10 && bank_sel_reg;
    assign aux_wr_11_12 = wr_strobe && hit_11_12 && bank_sel_reg;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bank_sel_reg <= input_priority_pkg::PATH_BANK_SELECT_RESET;
        end
        else if (wr_strobe && hit_select)
        begin
            bank_sel_reg <=
                wr_data[input_priority_pkg::PATH_BANK_SELECT_BIT];
        end
    end

    prio_path_copy #(
        .RESET_9_10(input_priority_pkg::INPUT9_10_MAIN_RESET),
        .RESET_11_12(input_priority_pkg::INPUT11_12_MAIN_RESET)
    ) u_main_copy (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_9_10(main_wr_9_10),
        .wr_11_12(main_wr_11_12),
        .wr_data(wr_data),
        .pair_9_10_reg(main_9_10),
        .pair_11_12_reg(main_11_12)
    );

    prio_path_copy #(
        .RESET_9_10(input_priority_pkg::INPUT9_10_AUX_RESET),
        .RESET_11_12(input_priority_pkg::INPUT11_12_AUX_RESET)
    ) u_aux_copy (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_9_10(aux_wr_9_10),
        .wr_11_12(aux_wr_11_12),
        .wr_data(wr_data),
        .pair_9_10_reg(aux_9_10),
        .pair_11_12_reg(aux_11_12)
    );

    always_comb
    begin
        rd_next = input_priority_pkg::READ_IDLE_VALUE;
        if (rd_strobe)
        begin
            if (hit_9_10)
            begin
                rd_next = bank_sel_reg ? aux_9_10 : main_9_10;
            end
            else if (hit_11_12)
            begin
                rd_next = bank_sel_reg ? aux_11_12 : main_11_12;
            end
            else if (hit_select)
            begin
                rd_next[input_priority_pkg::PATH_BANK_SELECT_BIT] =
                    bank_sel_reg;
            end
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_reg <= input_priority_pkg::READ_IDLE_VALUE;
        end
        else
        begin
            rd_data_reg <= rd_next;
        end
    end

    always_comb
    begin
        main_prio_next[0] = main_9_10[input_priority_pkg::LOW_FIELD_LSB +: 4];
        main_prio_next[1] = main_9_10[input_priority_pkg::HIGH_FIELD_LSB +: 4];
        main_prio_next[2] =
            main_11_12[input_priority_pkg::LOW_FIELD_LSB +: 4];
        main_prio_next[3] =
            main_11_12[input_priority_pkg::HIGH_FIELD_LSB +: 4];
        aux_prio_next[0] = aux_9_10[input_priority_pkg::LOW_FIELD_LSB +: 4];
        aux_prio_next[1] = aux_9_10[input_priority_pkg::HIGH_FIELD_LSB +: 4];
        aux_prio_next[2] = aux_11_12[input_priority_pkg::LOW_FIELD_LSB +: 4];
        aux_prio_next[3] = aux_11_12[input_priority_pkg::HIGH_FIELD_LSB +: 4];
    end

    prio_pick #(
        .N(input_priority_pkg::NUM_INPUTS),
        .W(input_priority_pkg::PRIO_W),
        .IDX_W(2)
    ) u_main_pick (
        .prio(main_prio_next),
        .available(input_available),
        .eligible(main_elig_next),
        .best_valid(main_valid_next),
        .best_idx(main_idx_next),
        .best_prio(main_bprio_next)
    );

    prio_pick #(
        .N(input_priority_pkg::NUM_INPUTS),
        .W(input_priority_pkg::PRIO_W),
        .IDX_W(2)
    ) u_aux_pick (
        .prio(aux_prio_next),
        .available(input_available),
        .eligible(aux_elig_next),
        .best_valid(aux_valid_next),
        .best_idx(aux_idx_next),
        .best_prio(aux_bprio_next)
    );

    for (genvar g = 0; g < input_priority_pkg::NUM_INPUTS; g++)
    begin : g_prio
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                main_prio_reg[g] <= input_priority_pkg::PRIO_DISABLED;
                aux_prio_reg[g] <= input_priority_pkg::PRIO_DISABLED;
            end
            else
            begin
                main_prio_reg[g] <= main_prio_next[g];
                aux_prio_reg[g] <= aux_prio_next[g];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_elig_reg <= 4'h0;
        end
        else
        begin
            main_elig_reg <= main_elig_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_valid_reg <= 1'b0;
            main_idx_reg <= 2'h0;
            main_bprio_reg <= input_priority_pkg::PRIO_DISABLED;
        end
        else
        begin
            main_valid_reg <= main_valid_next;
            main_idx_reg <= main_idx_next;
            main_bprio_reg <= main_bprio_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aux_elig_reg <= 4'h0;
        end
        else
        begin
            aux_elig_reg <= aux_elig_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aux_valid_reg <= 1'b0;
            aux_idx_reg <= 2'h0;
            aux_bprio_reg <= input_priority_pkg::PRIO_DISABLED;
        end
        else
        begin
            aux_valid_reg <= aux_valid_next;
            aux_idx_reg <= aux_idx_next;
            aux_bprio_reg <= aux_bprio_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign rd_data = rd_data_reg;
    assign path_bank_select = bank_sel_reg;
    assign main_prio = main_prio_reg;
    assign main_eligible = main_elig_reg;
    assign main_best_valid = main_valid_reg;
    assign main_best_idx = main_idx_reg;
    assign main_best_prio = main_bprio_reg;
    assign aux_prio = aux_prio_reg;
    assign aux_eligible = aux_elig_reg;
    assign aux_best_valid = aux_valid_reg;
    assign aux_best_idx = aux_idx_reg;
    assign aux_best_prio = aux_bprio_reg;

endmodule // input_priority_config_regs

// [test/input_priority_config_regs_sva.sv]
`timescale 1ns/1ps

module input_priority_config_regs_chk (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Processor port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_data,
    // Selection side.
    input wire logic [3:0] input_available,
    input wire logic path_bank_select,
    input wire logic [3:0][3:0] main_prio,
    input wire logic [3:0] main_eligible,
    input wire logic main_best_valid,
    input wire logic [1:0] main_best_idx,
    input wire logic [3:0] main_best_prio,
    input wire logic [3:0][3:0] aux_prio
);
    logic [1:0] up_cnt;
    logic [3:0] nz;
    logic beaten;
    logic hit;

    // Counts edges since reset so start-up loads are not taken as writes.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end

    always_comb
    begin
        beaten = 1'b0;
        for (int j = 0; j < 4; j++)
        begin
            nz[j] = main_prio[j] != 4'h0;
            if (main_eligible[j] && (main_prio[j] < main_best_prio ||
                (main_prio[j] == main_best_prio && j < main_best_idx)))
                beaten = 1'b1;
        end
    end

    assign hit = addr == 8'h1C || addr == 8'h1D || addr == 8'h4B;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_read_main_copy:
        assert property (rd_strobe && addr == 8'h1C && !path_bank_select
            |=> rd_data == {main_prio[1], main_prio[0]})
            else $error("main copy read wrong");
    a_read_aux_copy:
        assert property (rd_strobe && addr == 8'h1D && path_bank_select
            |=> rd_data == {aux_prio[3], aux_prio[2]})
            else $error("aux copy read wrong");
    a_read_quiet:
        assert property (!(rd_strobe && hit) |=> rd_data == 8'h00)
            else $error("read data not zero");
    a_bank_read:
        assert property (rd_strobe && addr == 8'h4B
            |=> rd_data == {3'h0, $past(path_bank_select), 4'h0})
            else $error("bank select read wrong");
    a_bank_write:
        assert property (wr_strobe && addr == 8'h4B
            |=> path_bank_select == $past(wr_data[4]))
            else $error("bank select not stored");
    a_write_main_copy:
        assert property (wr_strobe && addr == 8'h1C && !path_bank_select
            |-> ##2 {main_prio[1], main_prio[0]} == $past(wr_data, 2))
            else $error("main copy write lost");
    a_aux_hold:
        assert property (up_cnt == 2'h3 && $changed(aux_prio)
            |-> $past(wr_strobe, 2) && $past(path_bank_select, 2))
            else $error("aux copy changed without aux write");
    a_eligible_rule:
        assert property (main_eligible == (nz & $past(input_available)))
            else $error("eligible set wrong");
    a_best_pick:
        assert property (main_best_valid == (|main_eligible) &&
            (!main_best_valid || (main_eligible[main_best_idx] && !beaten &&
            main_best_prio == main_prio[main_best_idx])))
            else $error("best pick wrong");
endmodule // input_priority_config_regs_chk

// [test/tb_input_priority_config_regs.sv]
`timescale 1ns/1ps

module tb_input_priority_config_regs;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [3:0] input_available = 4'hF;
    logic [7:0] rd_data;
    logic path_bank_select;
    logic [3:0][3:0] main_prio;
    logic [3:0][3:0] aux_prio;
    logic [3:0] main_eligible;
    logic [3:0] aux_eligible;
    logic main_best_valid;
    logic aux_best_valid;
    logic [1:0] main_best_idx;
    logic [1:0] aux_best_idx;
    logic [3:0] main_best_prio;
    logic [3:0] aux_best_prio;
    logic [7:0] mdl [0:1][0:1];
    logic bank = 1'b0;
    int seed = 52940;
    int n_mismatch = 0;
    int n_compared = 0;
    wire [7:0] mb = {1'b0, main_best_valid, main_best_idx, main_best_prio};
    wire [7:0] ab = {1'b0, aux_best_valid, aux_best_idx, aux_best_prio};
    wire [7:0] el = {main_eligible, aux_eligible};

    always #5 sys_clk = ~sys_clk;

    input_priority_config_regs dut (
        .sys_clk, .rst_b, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
        .input_available, .path_bank_select, .main_prio, .main_eligible,
        .main_best_valid, .main_best_idx, .main_best_prio, .aux_prio,
        .aux_eligible, .aux_best_valid, .aux_best_idx, .aux_best_prio
    );

    task automatic conclude();
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_sel(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: selection %h expected %h", $time,
                got, exp);
        end
    endtask

    // An input is eligible when available with a nonzero priority.
    function automatic logic [3:0] elig(input logic b);
        logic [3:0] e;
        for (int i = 0; i < 4; i++)
        begin
            e[i] = input_available[i] &&
                mdl[b][i / 2][(i % 2) * 4 +: 4] != 4'h0;
        end
        return e;
    endfunction

    // Smallest nonzero available value wins, lower input on a tie.
    function automatic logic [7:0] pick(input logic [15:0] p,
        input logic [3:0] av);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 3; i >= 0; i--)
        begin
            if (av[i] && p[i*4+:4] != 4'h0 && (!r[6] || p[i*4+:4] <= r[3:0]))
                r = {2'h1, 2'(i), p[i*4+:4]};
        end
        return r;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        rd_strobe <= 1'b0;
        if (a == 8'h4B)
            bank = d[4];
        else if (a == 8'h1C || a == 8'h1D)
            mdl[bank][a[0]] = d;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a == 8'h4B) ? {3'h0, bank, 4'h0} : 8'h00;
        if (a == 8'h1C || a == 8'h1D)
            e = mdl[bank][a[0]];
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        wr_strobe <= 1'b0;
        input_available <= 4'($random(seed));
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1;
        chk(rd_data, e);
        chk_sel(mb, pick({mdl[0][1], mdl[0][0]}, input_available));
        chk_sel(ab, pick({mdl[1][1], mdl[1][0]}, input_available));
        chk_sel(el, {elig(1'b0), elig(1'b1)});
    endtask

    initial
    begin
        logic [10:0] r;
        logic [7:0] a;
        mdl[0][0] = 8'hBA;
        mdl[1][0] = 8'hBA;
        mdl[0][1] = 8'hDC;
        mdl[1][1] = 8'h00;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int b = 1; b >= 0; b--)
        begin
            wr(8'h4B, 8'(b << 4));
            rd(8'h1C);
            rd(8'h1D);
        end
        wr(8'h1C, 8'h33);
        wr(8'h1D, 8'h03);
        rd(8'h1D);
        wr(8'h1E, 8'hFF);
        rd(8'h1E);
        rd(8'h4B);
        for (int i = 0; i < 400; i++)
        begin
            r = 11'($random(seed));
            a = r[9:8] == 2'h0 ? 8'h4B : 8'h1B + 8'(r[9:8]);
            if (r[9:8] == 2'h3)
                a = r[7:0];
            if (r[10])
                wr(a, 8'($random(seed)));
            else
                rd(a);
        end
        rd(8'h1C);
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        conclude();
    end
endmodule // tb_input_priority_config_regs

bind input_priority_config_regs input_priority_config_regs_chk chk (
    .sys_clk, .rst_b, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
    .input_available, .path_bank_select, .main_prio, .main_eligible,
    .main_best_valid, .main_best_idx, .main_best_prio, .aux_prio
);
